// ### src/aorar_regs.sv
// Output lane and reset control register with the fault flag register.
`timescale 1ns/1ns

// Operation
// - The top four bits of every frame carry the register address used to select the register.
// - Lane select 00 sends results on lanes A and B.
// - Lane select 01 or 11 sends all results on lane A only.
// - Lane select 10 sends results on lanes A to D, with lane D sharing the alert pin.
// - Command 0x3C gives a soft reset that keeps the lane select and the setup error flag.
// - A soft reset clears the write CRC error and channel D high flags, but not the setup error flag.
// - Command 0xFF gives a hard reset that returns every register to its default.
// - Any other command value causes no reset.
// - A write rejected for a bad CRC sets the write CRC error flag at bit 9.
// - The write CRC error and channel D high flags stay set until the alert register is read or a soft or hard reset is given.
// - A failed startup configuration load sets the setup error flag at bit 8.
// - Reading the alert register does not clear the setup error flag.
// - A hard reset clears the setup error flag and reruns the startup load.
// - A channel D result above the high threshold sets the flag at bit 7.
// - The alert pin enable only acts while the lane select is 01.
// - With write CRC checking on, a write frame without a valid CRC is discarded.
module aorar_regs
(
   input  wire logic                             mclk,
   input  wire logic                             reset_n,
   input  wire aorar_pkg::aorar_frame_t          frame_i,
   input  wire logic                             crc_write_en,
   input  wire logic                             alert_enable,
   input  wire logic                             chd_valid,
   input  wire logic [aorar_pkg::ALERT_W-1:0]    chd_result,
   input  wire logic [aorar_pkg::ALERT_W-1:0]    chd_high_threshold,
   input  wire logic                             cfg_load_ok,
   output aorar_pkg::aorar_rsp_t                 rsp_q,
   output logic [3:0]                            lane_en_q,
   output logic                                  pin_d_alert_mode_q,
   output logic                                  alert_pin_q,
   output logic                                  soft_reset_q,
   output logic                                  hard_reset_q,
   output logic                                  setup_busy_q
);

   // Lane select to lane enables, one bit per lane A to D.
   function automatic logic [3:0] lane_decode(input logic [1:0] sel);
      logic [3:0] en;
      case (sel)
         aorar_pkg::LANE_TWO:   en = aorar_pkg::EN_TWO;
         aorar_pkg::LANE_FOUR:  en = aorar_pkg::EN_FOUR;
         default:               en = aorar_pkg::EN_ONE;
      endcase
      return en;
   endfunction

   logic [3:0]   addr;
   logic [11:0]  data;
   logic         is_wr;
   logic         crc_reject;
   logic         cfg_wr;
   logic         cmd_soft;
   logic         cmd_hard;
   logic         rd_alert;
   logic         chd_hit;
   logic         setup_fail;
   logic [1:0]   lanes_q;
   logic [1:0]   lanes_d;
   logic         wcrc_q;
   logic         wcrc_d;
   logic         dhigh_q;
   logic         dhigh_d;
   logic         setup_q;
   logic         setup_d;
   aorar_pkg::aorar_rsp_t  rsp_d;
   logic [3:0]   lane_en_d;
   logic         pin_d_alert_mode_d;
   logic         alert_pin_d;

   // ==========================================================
   // Frame decode
   // ==========================================================
   always_comb
   begin
      addr       = frame_i.word[aorar_pkg::ADDR_MSB:aorar_pkg::ADDR_LSB];
      data       = frame_i.word[aorar_pkg::RSVD_MSB:0];
      is_wr      = frame_i.valid & frame_i.write;
      crc_reject = is_wr & crc_write_en & ~frame_i.crc_ok;
      cfg_wr     = is_wr & ~crc_reject & (addr == aorar_pkg::ADDR_CFG2);
      cmd_soft   = cfg_wr &
                   (data[aorar_pkg::CMD_MSB:aorar_pkg::CMD_LSB] ==
                    aorar_pkg::CMD_SOFT);
      cmd_hard   = cfg_wr &
                   (data[aorar_pkg::CMD_MSB:aorar_pkg::CMD_LSB] ==
                    aorar_pkg::CMD_HARD);
      rd_alert   = frame_i.valid & ~frame_i.write &
                   (addr == aorar_pkg::ADDR_ALERT);
      chd_hit    = chd_valid & (chd_result > chd_high_threshold);
   end

   // ==========================================================
   // Register state
   // ==========================================================
   // A command frame carries its own lane bits, but a reset command is
   // not taken as a lane change, so a soft reset keeps the lane mode.
   always_comb
   begin
      lanes_d = lanes_q;
      if (cfg_wr && !cmd_soft && !cmd_hard)
      begin
         lanes_d = data[aorar_pkg::LANE_MSB:aorar_pkg::LANE_LSB];
      end
      if (cmd_hard)
      begin
         lanes_d = aorar_pkg::LANE_RESET;
      end
      wcrc_d  = (wcrc_q & ~rd_alert) | crc_reject;
      dhigh_d = (dhigh_q & ~rd_alert) | chd_hit;
      if (cmd_soft || cmd_hard)
      begin
         wcrc_d  = 1'b0;
         dhigh_d = 1'b0;
      end
      setup_d = setup_q | setup_fail;
      if (cmd_hard)
      begin
         setup_d = 1'b0;
      end
   end

   // ==========================================================
   // Read path and output pins
   // ==========================================================
   always_comb
   begin
      rsp_d.valid = frame_i.valid & ~frame_i.write;
      rsp_d.word  = {addr, 12'h000};
      if (addr == aorar_pkg::ADDR_CFG2)
      begin
         rsp_d.word[aorar_pkg::LANE_MSB:aorar_pkg::LANE_LSB] = lanes_q;
      end
      else if (addr == aorar_pkg::ADDR_ALERT)
      begin
         rsp_d.word[aorar_pkg::WCRC_BIT]  = wcrc_q;
         rsp_d.word[aorar_pkg::SETUP_BIT] = setup_q;
         rsp_d.word[aorar_pkg::DHIGH_BIT] = dhigh_q;
      end
      if (!rsp_d.valid)
      begin
         rsp_d.word = rsp_q.word;
      end
      lane_en_d          = lane_decode(lanes_d);
      // In four lane mode the shared pin carries lane D data instead.
      pin_d_alert_mode_d = alert_enable &
                           (lanes_d == aorar_pkg::LANE_ONE_A);
      alert_pin_d        = pin_d_alert_mode_d & (wcrc_d | dhigh_d);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lanes_q            <= aorar_pkg::LANE_RESET;
         wcrc_q             <= 1'b0;
         dhigh_q            <= 1'b0;
         setup_q            <= 1'b0;
         rsp_q              <= '0;
         lane_en_q          <= aorar_pkg::EN_TWO;
         pin_d_alert_mode_q <= 1'b0;
         alert_pin_q        <= 1'b0;
         soft_reset_q       <= 1'b0;
         hard_reset_q       <= 1'b0;
      end
      else
      begin
         lanes_q            <= lanes_d;
         wcrc_q             <= wcrc_d;
         dhigh_q            <= dhigh_d;
         setup_q            <= setup_d;
         rsp_q              <= rsp_d;
         lane_en_q          <= lane_en_d;
         pin_d_alert_mode_q <= pin_d_alert_mode_d;
         alert_pin_q        <= alert_pin_d;
         soft_reset_q       <= cmd_soft;
         hard_reset_q       <= cmd_hard;
      end
   end

   // ==========================================================
   // Startup load
   // ==========================================================
   aorar_setup_loader u_loader
   (
      .mclk    (mclk),
      .reset_n (reset_n),
      .restart (cmd_hard),
      .load_ok (cfg_load_ok),
      .busy_q  (setup_busy_q),
      .fail_q  (setup_fail)
   );

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence s_hard_cmd;
      cmd_hard;
   endsequence

   sequence s_hard_done;
      !setup_q && setup_busy_q && hard_reset_q &&
      lanes_q == aorar_pkg::LANE_RESET;
   endsequence

   sequence s_soft_done;
      soft_reset_q && !wcrc_q && !dhigh_q;
   endsequence

   property p_hard_rerun;
      s_hard_cmd |=> s_hard_done;
   endproperty

   a_addr_echo_rd: assert property (
      (frame_i.valid && !frame_i.write) |=>
      (rsp_q.valid && rsp_q.word[15:12] == $past(addr)))
      else $error("read answer lost its address");
   a_lane_two_mode: assert property (
      lanes_q == aorar_pkg::LANE_TWO |-> lane_en_q == 4'h3)
      else $error("two lane mode enables wrong lanes");
   a_lane_one_mode: assert property (
      (lanes_q == aorar_pkg::LANE_ONE_A || lanes_q == aorar_pkg::LANE_ONE_B)
      |-> lane_en_q == 4'h1)
      else $error("one lane mode enables wrong lanes");
   a_lane_four_mode: assert property (
      lanes_q == aorar_pkg::LANE_FOUR |-> lane_en_q == 4'hF &&
      !pin_d_alert_mode_q)
      else $error("four lane mode wrong");
   a_soft_keeps_lanes: assert property (
      cmd_soft |=> $stable(lanes_q) && !hard_reset_q)
      else $error("soft reset changed the lane mode");
   a_soft_clears_flags: assert property (
      cmd_soft |=> s_soft_done)
      else $error("soft reset left a flag set");
   a_hard_reset_rerun: assert property (p_hard_rerun)
      else $error("hard reset did not restore defaults");
   a_other_cmd_quiet: assert property (
      (cfg_wr && !cmd_soft && !cmd_hard) |=>
      !soft_reset_q && !hard_reset_q)
      else $error("unknown command caused a reset");
   a_crc_flag_set: assert property (
      crc_reject |=> wcrc_q)
      else $error("crc failure not flagged");
   a_sticky_hold: assert property (
      (wcrc_q && !rd_alert && !cmd_soft && !cmd_hard) |=> wcrc_q)
      else $error("crc flag dropped without a read");
   a_dhigh_hold: assert property (
      (dhigh_q && !rd_alert && !cmd_soft && !cmd_hard) |=> dhigh_q)
      else $error("channel d flag dropped without a read");
   a_read_clears: assert property (
      (rd_alert && !chd_hit) |=> !dhigh_q && !wcrc_q)
      else $error("read did not clear sticky flags");
   a_setup_set: assert property (
      (setup_fail && !cmd_hard) |=> setup_q)
      else $error("load failure not flagged");
   a_setup_survives: assert property (
      (setup_q && !cmd_hard) |=> setup_q)
      else $error("setup flag cleared without hard reset");
   a_dhigh_set: assert property (
      (chd_hit && !cmd_soft && !cmd_hard) |=> dhigh_q)
      else $error("channel d high alert not flagged");
   a_alert_gate: assert property (
      lanes_q != aorar_pkg::LANE_ONE_A |-> !pin_d_alert_mode_q &&
      !alert_pin_q)
      else $error("alert pin active outside one lane mode");
   a_crc_discard: assert property (
      crc_reject |=> $stable(lanes_q) && !soft_reset_q && !hard_reset_q)
      else $error("bad crc write took effect");
   a_reserved_zero: assert property (
      rsp_q.valid |-> rsp_q.word[11:10] == 2'b00)
      else $error("reserved bits read nonzero");

endmodule

// ### src/aorar_pkg.sv
// Package of constants and carrier types for the lane and alert registers.
package aorar_pkg;

   // ==========================================================
   // Frame layout
   // ==========================================================
   localparam int          ADDR_MSB    = 15;
   localparam int          ADDR_LSB    = 12;
   localparam int          RSVD_MSB    = 11;
   localparam int          RSVD_LSB    = 10;
   localparam int          LANE_MSB    = 9;
   localparam int          LANE_LSB    = 8;
   localparam int          CMD_MSB     = 7;
   localparam int          CMD_LSB     = 0;

   // ==========================================================
   // Register addresses
   // ==========================================================
   localparam logic [3:0]  ADDR_CFG2   = 4'h2;
   localparam logic [3:0]  ADDR_ALERT  = 4'h3;

   // ==========================================================
   // Alert register bit positions
   // ==========================================================
   localparam int          WCRC_BIT    = 9;
   localparam int          SETUP_BIT   = 8;
   localparam int          DHIGH_BIT   = 7;

   // ==========================================================
   // Lane modes, commands and reset values
   // ==========================================================
   localparam logic [1:0]  LANE_TWO    = 2'h0;
   localparam logic [1:0]  LANE_ONE_A  = 2'h1;
   localparam logic [1:0]  LANE_FOUR   = 2'h2;
   localparam logic [1:0]  LANE_ONE_B  = 2'h3;
   localparam logic [1:0]  LANE_RESET  = 2'h0;
   localparam logic [7:0]  CMD_SOFT    = 8'h3C;
   localparam logic [7:0]  CMD_HARD    = 8'hFF;
   localparam logic [3:0]  EN_TWO      = 4'h3;
   localparam logic [3:0]  EN_ONE      = 4'h1;
   localparam logic [3:0]  EN_FOUR     = 4'hF;
   localparam int          ALERT_W     = 12;

   // ==========================================================
   // Startup configuration load timing
   // ==========================================================
   localparam int          LOAD_CYCLES = 16;
   localparam int          LOAD_CNT_W  = 5;
   localparam logic [4:0]  LOAD_LAST   = 5'h0F;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        crc_ok;
      logic [15:0] word;
   } aorar_frame_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } aorar_rsp_t;

endpackage

// ### src/aorar_setup_loader.sv
// Startup configuration loader that reports a failed load.
`timescale 1ns/1ns

module aorar_setup_loader
(
   input  wire logic  mclk,
   input  wire logic  reset_n,
   input  wire logic  restart,
   input  wire logic  load_ok,
   output logic       busy_q,
   output logic       fail_q
);

   typedef enum logic [1:0] {AORAR_LD_LOAD, AORAR_LD_DONE} aorar_ld_t;

   aorar_ld_t                          state_q;
   aorar_ld_t                          state_d;
   logic [aorar_pkg::LOAD_CNT_W-1:0]   cnt_q;
   logic [aorar_pkg::LOAD_CNT_W-1:0]   cnt_d;
   logic                               busy_d;
   logic                               fail_d;

   // ==========================================================
   // Load sequencer
   // ==========================================================
   // A restart abandons a load in progress, so a stale result from
   // the aborted run never reaches the setup flag.
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      fail_d  = 1'b0;
      case (state_q)
         AORAR_LD_LOAD:
         begin
            if (cnt_q == aorar_pkg::LOAD_LAST)
            begin
               state_d = AORAR_LD_DONE;
               fail_d  = ~load_ok;
            end
            else
            begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         AORAR_LD_DONE:
         begin
            cnt_d = '0;
         end
         default:
         begin
            state_d = AORAR_LD_DONE;
         end
      endcase
      if (restart)
      begin
         state_d = AORAR_LD_LOAD;
         cnt_d   = '0;
         fail_d  = 1'b0;
      end
      busy_d = (state_d == AORAR_LD_LOAD);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= AORAR_LD_LOAD;
         cnt_q   <= '0;
         busy_q  <= 1'b1;
         fail_q  <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         busy_q  <= busy_d;
         fail_q  <= fail_d;
      end
   end

endmodule

// ### verification/aorar_host_model.sv
// Host serial controller model that offers register frames.
`timescale 1ns/1ns

module aorar_host_model
(
   input  wire logic               mclk,
   output aorar_pkg::aorar_frame_t frame
);
   // ==========================================================
   // Frame driver
   // ==========================================================
   initial frame = '0;

   // The frame stays up until release_bus or the next send, so two
   // sends in a row give back-to-back frames.
   task automatic send(input logic wr, input logic crc,
                       input logic [3:0] addr, input logic [11:0] data);
      @(negedge mclk);
      frame.valid  = 1'b1;
      frame.write  = wr;
      frame.crc_ok = crc;
      frame.word   = {addr, data};
   endtask

   // A released frame drops valid and shows the other lines inverted, never their last value.
   task automatic release_bus;
      @(negedge mclk);
      frame.valid  = 1'b0;
      frame.write  = ~frame.write;
      frame.crc_ok = ~frame.crc_ok;
      frame.word   = ~frame.word;
   endtask

   task automatic hard_reset;
      send(1'b1, 1'b1, aorar_pkg::ADDR_CFG2, 12'h0FF);
      release_bus;
   endtask
endmodule

// ### verification/aorar_regs_test.sv
// Self-checking testbench for the lane and alert registers.
`timescale 1ns/1ns

module aorar_regs_test;
   logic                           mclk = 1'b0;
   logic                           reset_n = 1'b0;
   aorar_pkg::aorar_frame_t        frame;
   logic                           crc_write_en;
   logic                           alert_enable;
   logic                           chd_valid;
   logic                           cfg_load_ok;
   logic [aorar_pkg::ALERT_W-1:0]  chd_result;
   logic [aorar_pkg::ALERT_W-1:0]  thr;
   aorar_pkg::aorar_rsp_t          rsp_q;
   logic [3:0]                     lane_en_q;
   logic                           pin_d_alert_mode_q;
   logic                           alert_pin_q;
   logic                           soft_reset_q;
   logic                           hard_reset_q;
   logic                           setup_busy_q;
   logic [15:0]                    exp_q[$];
   logic [1:0]                     mode;
   logic [7:0]                     cmd;
   logic [3:0]                     en_exp;
   int                             bad_count = 0;
   int                             tests_run = 0;

   always #4 mclk = ~mclk;

   aorar_host_model host (.mclk(mclk), .frame(frame));

   aorar_regs dut
   (
      .mclk               (mclk),
      .reset_n            (reset_n),
      .frame_i            (frame),
      .crc_write_en       (crc_write_en),
      .alert_enable       (alert_enable),
      .chd_valid          (chd_valid),
      .chd_result         (chd_result),
      .chd_high_threshold (thr),
      .cfg_load_ok        (cfg_load_ok),
      .rsp_q              (rsp_q),
      .lane_en_q          (lane_en_q),
      .pin_d_alert_mode_q (pin_d_alert_mode_q),
      .alert_pin_q        (alert_pin_q),
      .soft_reset_q       (soft_reset_q),
      .hard_reset_q       (hard_reset_q),
      .setup_busy_q       (setup_busy_q)
   );

   // ==========================================================
   // Checking and closing
   // ==========================================================
   task automatic test_done;
      $display("compared %0d, mismatched %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic cmp_lvl(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t level got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask

   task automatic cmp_rsp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask

   // Read answers are taken off the queue in order as they appear.
   always @(negedge mclk)
      if (rsp_q.valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp_rsp(rsp_q.word, ~rsp_q.word);
         else
            cmp_rsp(rsp_q.word, exp_q.pop_front());
      end

   initial
   begin
      repeat (20000) @(negedge mclk);
      bad_count++;
      test_done;
   end

   // ==========================================================
   // Stimulus tasks
   // ==========================================================
   task automatic rd(input logic [3:0] addr, input logic [15:0] exp);
      exp_q.push_back(exp);
      host.send(1'b0, 1'b1, addr, 12'h000);
      host.release_bus;
   endtask

   task automatic wr(input logic [3:0] a, input logic [11:0] d,
                     input logic crc);
      host.send(1'b1, crc, a, d);
      host.release_bus;
   endtask

   task automatic pulse(input logic [aorar_pkg::ALERT_W-1:0] v);
      @(negedge mclk);
      chd_valid  = 1'b1;
      chd_result = v;
      @(negedge mclk);
      chd_valid  = 1'b0;
      chd_result = ~v;
   endtask

   // Busy waits are bounded so a stuck loader ends the run.
   task automatic wait_load;
      int n;
      for (n = 0; n < 100 && setup_busy_q !== 1'b0; n++)
         @(negedge mclk);
      if (n == 100)
      begin
         bad_count++;
         test_done;
      end
      repeat (3) @(negedge mclk);
   endtask

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial
   begin
      void'($urandom(32'h3cc26827));
      crc_write_en = 1'b0;
      alert_enable = 1'b1;
      chd_valid    = 1'b0;
      chd_result   = '0;
      cfg_load_ok  = 1'b0;
      thr          = {1'b0, 11'($urandom)};
      repeat (12) @(negedge mclk);
      reset_n = 1'b1;
      cmp_lvl({15'h0, setup_busy_q}, 16'h0001);
      wait_load;
      exp_q.push_back(16'h3100);
      exp_q.push_back(16'h3100);
      host.send(1'b0, 1'b1, aorar_pkg::ADDR_ALERT, 12'h000);
      host.send(1'b0, 1'b1, aorar_pkg::ADDR_ALERT, 12'h000);
      host.release_bus;
      $display("setup flag test done");

      for (int m = 0; m < 4; m++)
      begin
         mode = 2'(m);
         do cmd = 8'($urandom);
         while (cmd == aorar_pkg::CMD_SOFT || cmd == aorar_pkg::CMD_HARD);
         wr(aorar_pkg::ADDR_CFG2, {2'h3, mode, cmd}, 1'b1);
         en_exp = mode == aorar_pkg::LANE_TWO  ? aorar_pkg::EN_TWO :
                  mode == aorar_pkg::LANE_FOUR ? aorar_pkg::EN_FOUR :
                  aorar_pkg::EN_ONE;
         cmp_lvl({12'h0, lane_en_q}, {12'h0, en_exp});
         cmp_lvl({14'h0, soft_reset_q, hard_reset_q}, 16'h0);
         rd(aorar_pkg::ADDR_CFG2, {4'h2, 2'h0, mode, 8'h00});
         cmp_lvl({15'h0, pin_d_alert_mode_q},
                 {15'h0, mode == aorar_pkg::LANE_ONE_A});
      end
      $display("lane mode test done");

      wr(aorar_pkg::ADDR_CFG2, 12'h100, 1'b1);
      // The enable itself must gate the shared pin in one lane mode.
      alert_enable = 1'b0;
      @(negedge mclk);
      cmp_lvl({15'h0, pin_d_alert_mode_q}, 16'h0000);
      alert_enable = 1'b1;
      crc_write_en = 1'b1;
      wr(aorar_pkg::ADDR_CFG2, 12'h200, 1'b0);
      cmp_lvl({12'h0, lane_en_q}, {12'h0, aorar_pkg::EN_ONE});
      rd(aorar_pkg::ADDR_ALERT, 16'h3300);
      rd(aorar_pkg::ADDR_ALERT, 16'h3100);
      crc_write_en = 1'b0;
      $display("write check test done");

      pulse(thr);
      pulse(thr + 1'b1);
      repeat (2) @(negedge mclk);
      cmp_lvl({15'h0, alert_pin_q}, 16'h0001);
      rd(aorar_pkg::ADDR_ALERT, 16'h3180);
      rd(aorar_pkg::ADDR_ALERT, 16'h3100);
      $display("high alert test done");

      pulse(thr + 1'b1);
      wr(aorar_pkg::ADDR_CFG2, 12'h03C, 1'b1);
      cmp_lvl({11'h0, soft_reset_q, lane_en_q}, 16'h0011);
      rd(aorar_pkg::ADDR_ALERT, 16'h3100);
      rd(aorar_pkg::ADDR_CFG2, 16'h2100);
      $display("soft reset test done");

      cfg_load_ok = 1'b1;
      host.hard_reset;
      cmp_lvl({10'h0, hard_reset_q, setup_busy_q, lane_en_q},
              16'h0033);
      wait_load;
      rd(aorar_pkg::ADDR_ALERT, 16'h3000);
      rd(aorar_pkg::ADDR_CFG2, 16'h2000);
      wr(aorar_pkg::ADDR_ALERT, 12'hFFF, 1'b1);
      rd(4'h5, 16'h5000);
      rd(aorar_pkg::ADDR_ALERT, 16'h3000);
      $display("hard reset test done");

      repeat (3) @(negedge mclk);
      cmp_lvl(16'(exp_q.size()), 16'h0000);
      test_done;
   end
endmodule
